// *** cell_prot_defs.svh ***
// Constants for the cell protection fault timing block
`ifndef CELL_PROT_DEFS_SVH
`define CELL_PROT_DEFS_SVH

// Clock and timer base
`define CLK_MHZ        250
`define TICK_US        1
`define DLY_W          23
`define NUM_FAULTS     5

// Fault indices in the flattened fault vector
`define FLT_OVP        4
`define FLT_UVP        3
`define FLT_OCD        2
`define FLT_SCC        1
`define FLT_OCC        0

// Overcharge delay choices, microseconds
`define OVP_DLY0_US    250000
`define OVP_DLY1_US    1000000
`define OVP_DLY2_US    1250000
`define OVP_DLY3_US    4500000
// Over-discharge delay choices, microseconds
`define UVP_DLY0_US    20000
`define UVP_DLY1_US    96000
`define UVP_DLY2_US    125000
`define UVP_DLY3_US    144000
// Discharge overcurrent delay choices, microseconds
`define OCD_DLY0_US    8000
`define OCD_DLY1_US    16000
`define OCD_DLY2_US    20000
`define OCD_DLY3_US    48000
// Charge overcurrent delay choices, microseconds
`define OCC_DLY0_US    4000
`define OCC_DLY1_US    6000
`define OCC_DLY2_US    8000
`define OCC_DLY3_US    16000
// Short-circuit delay, fixed, microseconds
`define SCC_DLY_US     250
// Recovery delay, microseconds
`define RECOVERY_US    8000

// Threshold code ranges
`define OVP_THR_MAX    15
`define OCD_THR_MAX    22

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_CONFIG     8'h08
`define REG_EVENT      8'h0c

// Control fields
`define CTRL_FORCE_OFF 0
`define CTRL_RESET     32'h0000_0000

// Status fields
`define ST_CHG         0
`define ST_DSG         1
`define ST_TRIP_LSB    2
`define ST_BUSY_LSB    7
`define ST_ZV_BLOCK    12

// Config fields
`define CFG_OVP_THR    0
`define CFG_OCD_THR    4
`define CFG_SCC_THR    9
`define CFG_OVP_DLY    11
`define CFG_UVP_DLY    13
`define CFG_OCD_DLY    15
`define CFG_OCC_DLY    17
`define CFG_ZV_ALLOW   19

`endif

// *** cell_prot_pkg.sv ***
// Types shared by the cell protection fault timing block
package cell_prot_pkg;

	// One flag per protected condition
	typedef struct packed {
		logic ovp;
		logic uvp;
		logic ocd;
		logic scc;
		logic occ;
	} fault_vec_t;

	// Gate drive pair toward the external FETs
	typedef struct packed {
		logic charge_fet;
		logic discharge_fet;
	} fet_drive_t;

	// Per-fault sequencing state
	typedef enum logic {
		FS_NORMAL,
		FS_TRIPPED
	} fault_state_t;

endpackage

// *** fault_timer.sv ***
// Tick-based delay timer that restarts whenever its condition drops
`timescale 1ns/10ps
`default_nettype none

module fault_timer #(
	parameter int W = 23                  // Counter width
) (
	input  wire logic         clk_in,     // System clock
	input  wire logic         arst_n_in,  // Async reset, active low
	input  wire logic         tick_in,    // Timebase enable pulse
	input  wire logic         run_in,     // Condition present
	input  wire logic [W-1:0] limit_in,   // Ticks to expiry, at least 1
	output logic              expire_out, // One-cycle expiry pulse
	output logic              busy_out    // Timer counting
);

	logic [W-1:0] cnt_r;                  // Elapsed ticks
	logic         expire_r;               // Registered expiry
	logic         hit;                    // Last tick reached

	assign hit = (({1'b0, cnt_r} + {{W{1'b0}}, 1'b1}) >= {1'b0, limit_in});

	// Count while the condition holds; drop to zero the moment it goes away
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_r <= '0;
		end else if (!run_in || expire_r) begin
			cnt_r <= '0;
		end else if (tick_in) begin
			cnt_r <= hit ? '0 : cnt_r + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// Expiry pulse, suppressed if the condition vanished
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			expire_r  <= 1'b0;
		end else begin
			expire_r  <= run_in && tick_in && hit && !expire_r;
		end
	end

	assign expire_out = expire_r;
	assign busy_out   = run_in;

	// Expiry only follows a tick with the condition held
	a_expire_cause: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		expire_r |-> $past(run_in) && $past(tick_in))
		else $error("timer expired without a held condition");

	// A dropped condition leaves the counter at zero
	a_drop_clears: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		!run_in |=> cnt_r == '0)
		else $error("timer kept counting after its condition dropped");

endmodule

`default_nettype wire

// *** cell_protection_fault_timing.sv ***
// Fault sequencing and FET gate drive for a single-cell protector
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cell_prot_defs.svh"

module cell_protection_fault_timing #(
	parameter int         TICK_CYCLES  = `TICK_US * `CLK_MHZ, // Clocks per timebase tick
	parameter int         DELAY_DIV    = 1,                    // Delay divisor, for short runs
	parameter logic [1:0] OVP_DLY_SEL  = 2'h0,                 // Overcharge delay choice
	parameter logic [1:0] UVP_DLY_SEL  = 2'h0,                 // Over-discharge delay choice
	parameter logic [1:0] OCD_DLY_SEL  = 2'h0,                 // Discharge overcurrent delay
	parameter logic [1:0] OCC_DLY_SEL  = 2'h0,                 // Charge overcurrent delay
	parameter logic [3:0] OVP_THR_CODE = 4'h7,                 // Overcharge threshold code
	parameter logic [4:0] OCD_THR_CODE = 5'h02,                // Discharge overcurrent code
	parameter logic [1:0] SCC_THR_CODE = 2'h0,                 // Short threshold code
	parameter logic       ZV_ALLOW     = 1'b1                  // Zero-volt charging allowed
) (
	input  wire logic                     CLK_IN,                // System clock
	input  wire logic                     ARST_N_IN,             // Async reset, active low
	input  wire cell_prot_pkg::fault_vec_t DETECT_IN,            // Fault comparators tripped
	input  wire cell_prot_pkg::fault_vec_t RELEASE_IN,           // Release comparators met
	input  wire logic                     CHARGER_ABOVE_START_IN, // Charger over start level
	input  wire logic                     CELL_BELOW_INHIBIT_IN, // Cell under inhibit level
	input  wire logic                     PSEL,                  // APB select
	input  wire logic                     PENABLE,               // APB enable
	input  wire logic                     PWRITE,                // APB direction
	input  wire logic [7:0]               PADDR,                 // APB byte address
	input  wire logic [31:0]              PWDATA,                // APB write data
	output logic      [31:0]              PRDATA,                // APB read data
	output logic                          PREADY,                // APB ready
	output logic                          PSLVERR,               // APB error
	output logic                          CHARGE_FET_DRIVE_OUT,  // Charge FET gate, high on
	output logic                          DISCHARGE_FET_DRIVE_OUT // Discharge FET gate, high on
);

	localparam int W  = `DLY_W;      // Timer width
	localparam int NF = `NUM_FAULTS; // Fault count

	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	// Converts a delay in microseconds to ticks, never below one
	function automatic logic [W-1:0] to_ticks(input int unsigned us);
		int unsigned t;
		t = us / `TICK_US / DELAY_DIV;
		if (t < 1) begin
			t = 1;
		end
		return t[W-1:0];
	endfunction

	// Picks one of four factory delay choices
	function automatic int unsigned pick4(input logic [1:0] sel, input int unsigned a,
		input int unsigned b, input int unsigned c, input int unsigned d);
		unique case (sel)
			2'h0: return a;
			2'h1: return b;
			2'h2: return c;
			2'h3: return d;
		endcase
	endfunction

	// Factory delays, frozen at build time
	localparam logic [W-1:0] OVP_LIM = to_ticks(pick4(OVP_DLY_SEL, `OVP_DLY0_US, `OVP_DLY1_US,
		`OVP_DLY2_US, `OVP_DLY3_US));
	localparam logic [W-1:0] UVP_LIM = to_ticks(pick4(UVP_DLY_SEL, `UVP_DLY0_US, `UVP_DLY1_US,
		`UVP_DLY2_US, `UVP_DLY3_US));
	localparam logic [W-1:0] OCD_LIM = to_ticks(pick4(OCD_DLY_SEL, `OCD_DLY0_US, `OCD_DLY1_US,
		`OCD_DLY2_US, `OCD_DLY3_US));
	localparam logic [W-1:0] OCC_LIM = to_ticks(pick4(OCC_DLY_SEL, `OCC_DLY0_US, `OCC_DLY1_US,
		`OCC_DLY2_US, `OCC_DLY3_US));
	localparam logic [W-1:0] SCC_LIM = to_ticks(`SCC_DLY_US);
	localparam logic [W-1:0] REC_LIM = to_ticks(`RECOVERY_US);
	localparam int           TICK_W  = $clog2(TICK_CYCLES + 1);

	// Timebase
	logic [TICK_W-1:0] tick_cnt_r;  // Clocks within the tick
	logic              tick;        // One-cycle tick enable

	// Fault sequencing
	logic [NF-1:0]     det_v;       // Flattened detect inputs
	logic [NF-1:0]     rel_v;       // Flattened release inputs
	logic [W-1:0]      det_lim [NF]; // Detection delay per fault
	logic [NF-1:0]     run;         // Timer condition per fault
	logic [NF-1:0]     expire;      // Timer expiry pulses
	logic [NF-1:0]     busy;        // Timers counting
	logic [NF-1:0]     tripped;     // Fault latched
	cell_prot_pkg::fault_state_t st_r [NF]; // Per-fault state
	logic              zv_block;    // Zero-volt charge blocked

	// Gate drive
	cell_prot_pkg::fet_drive_t fet_r;   // Registered drive pair
	cell_prot_pkg::fet_drive_t fet_nxt; // Next drive pair

	// Register file
	logic [31:0]       ctrl_r;      // Control word
	logic [NF-1:0]     event_r;     // Sticky trip events
	logic [NF-1:0]     event_nxt;   // Next sticky events
	logic [NF-1:0]     tripped_d_r; // Trip flags, one cycle ago
	logic [31:0]       prdata_r;    // Registered read data
	logic [31:0]       rd_mux;      // Read data selected
	logic [31:0]       status_w;    // Status word
	logic [31:0]       config_w;    // Config word
	logic              rd_hit;      // Address maps a register
	logic              wr_acc;      // Write access phase
	logic              setup_rd;    // Read setup phase

	// Tick divider standing in for the internal oscillator
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			tick_cnt_r <= '0;
		end else if (tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + TICK_W'(1); // Cast keeps a one-bit counter legal
		end
	end

	assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

	assign det_v = DETECT_IN;
	assign rel_v = RELEASE_IN;

	// Detection delays by fault
	always_comb begin
		det_lim[`FLT_OVP] = OVP_LIM;
		det_lim[`FLT_UVP] = UVP_LIM;
		det_lim[`FLT_OCD] = OCD_LIM;
		det_lim[`FLT_SCC] = SCC_LIM;
		det_lim[`FLT_OCC] = OCC_LIM;
	end

	// One timer and state per fault; the same timer serves detection and recovery
	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++) begin : g_fault
			// Normal: watch detect input; tripped: watch release input
			assign run[gi] = (st_r[gi] == cell_prot_pkg::FS_NORMAL) ? det_v[gi] : rel_v[gi];

			fault_timer #(
				.W (W)
			) u_timer (
				.clk_in     (CLK_IN),
				.arst_n_in  (ARST_N_IN),
				.tick_in    (tick),
				.run_in     (run[gi]),
				.limit_in   ((st_r[gi] == cell_prot_pkg::FS_NORMAL) ? det_lim[gi] : REC_LIM),
				.expire_out (expire[gi]),
				.busy_out   (busy[gi])
			);

			// State changes only on expiry of the running timer
			always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
				if (!ARST_N_IN) begin
					st_r[gi] <= cell_prot_pkg::FS_NORMAL;
				end else if (expire[gi]) begin
					unique case (st_r[gi])
						cell_prot_pkg::FS_NORMAL:  st_r[gi] <= cell_prot_pkg::FS_TRIPPED;
						cell_prot_pkg::FS_TRIPPED: st_r[gi] <= cell_prot_pkg::FS_NORMAL;
					endcase
				end
			end

			assign tripped[gi] = (st_r[gi] == cell_prot_pkg::FS_TRIPPED);

			// Trip and release are both gated by an expiry
			a_trip_expiry: assert property ($changed(tripped[gi]) |-> $past(expire[gi]))
				else $error("fault state changed without a timer expiry");
		end
	endgenerate

	// A depleted cell may charge only from a strong enough charger
	always_comb begin
		if (ZV_ALLOW) begin
			zv_block = CELL_BELOW_INHIBIT_IN && !CHARGER_ABOVE_START_IN;
		end else begin
			zv_block = CELL_BELOW_INHIBIT_IN;
		end
	end

	// Gate drive: high turns the FET on, any latched fault on its path turns it off
	always_comb begin
		fet_nxt.charge_fet = !(tripped[`FLT_OVP] || tripped[`FLT_OCC] || zv_block ||
			ctrl_r[`CTRL_FORCE_OFF]);
		fet_nxt.discharge_fet = !(tripped[`FLT_UVP] || tripped[`FLT_OCD] || tripped[`FLT_SCC] ||
			ctrl_r[`CTRL_FORCE_OFF]);
	end

	// Registered drive; both off during reset, the safe state for the pack
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			fet_r <= '0;
		end else begin
			fet_r <= fet_nxt;
		end
	end

	assign CHARGE_FET_DRIVE_OUT    = fet_r.charge_fet;
	assign DISCHARGE_FET_DRIVE_OUT = fet_r.discharge_fet;

	// Charge path faults turn the charge FET off
	a_chg_off: assert property ((tripped[`FLT_OVP] || tripped[`FLT_OCC]) |=> !CHARGE_FET_DRIVE_OUT)
		else $error("charge drive high with a charge-path fault");

	// Discharge path faults turn the discharge FET off
	a_dsg_off: assert property ((tripped[`FLT_UVP] || tripped[`FLT_OCD] || tripped[`FLT_SCC])
		|=> !DISCHARGE_FET_DRIVE_OUT)
		else $error("discharge drive high with a discharge-path fault");

	// Healthy cell and current: both FETs on
	sequence s_all_clear;
		(tripped == '0) && !zv_block && !ctrl_r[`CTRL_FORCE_OFF];
	endsequence
	a_normal_on: assert property (s_all_clear |=> CHARGE_FET_DRIVE_OUT && DISCHARGE_FET_DRIVE_OUT)
		else $error("FET drive off with no fault present");

	// Depleted cell with weak charger never charges
	a_zv_charger: assert property (CELL_BELOW_INHIBIT_IN && !CHARGER_ABOVE_START_IN
		|=> !CHARGE_FET_DRIVE_OUT)
		else $error("zero-volt charge enabled below the charger start level");

	// Short trip requires short detection present two cycles before the trip
	sequence s_short_trip;
		$rose(tripped[`FLT_SCC]);
	endsequence
	a_short_delay: assert property (s_short_trip |-> $past(det_v[`FLT_SCC], 2))
		else $error("short trip without held detection");

	// A one-cycle discharge overcurrent blip never trips that fault
	a_blip_ignored: assert property ((st_r[`FLT_OCD] == cell_prot_pkg::FS_NORMAL) &&
		!det_v[`FLT_OCD] ##1 det_v[`FLT_OCD] ##1 !det_v[`FLT_OCD] |=> !tripped[`FLT_OCD] [*2])
		else $error("discharge overcurrent tripped on a short blip");

	// Factory selections, read back only; nothing at run time alters them
	always_comb begin
		config_w = '0;
		config_w[`CFG_OVP_THR +: 4] = OVP_THR_CODE;
		config_w[`CFG_OCD_THR +: 5] = OCD_THR_CODE;
		config_w[`CFG_SCC_THR +: 2] = SCC_THR_CODE;
		config_w[`CFG_OVP_DLY +: 2] = OVP_DLY_SEL;
		config_w[`CFG_UVP_DLY +: 2] = UVP_DLY_SEL;
		config_w[`CFG_OCD_DLY +: 2] = OCD_DLY_SEL;
		config_w[`CFG_OCC_DLY +: 2] = OCC_DLY_SEL;
		config_w[`CFG_ZV_ALLOW]     = ZV_ALLOW;
	end

	a_cfg_fixed: assert property ($stable(config_w))
		else $error("factory configuration changed at run time");

	// Live status word
	always_comb begin
		status_w = '0;
		status_w[`ST_CHG]              = fet_r.charge_fet;
		status_w[`ST_DSG]              = fet_r.discharge_fet;
		status_w[`ST_TRIP_LSB +: NF]   = tripped;
		status_w[`ST_BUSY_LSB +: NF]   = busy;
		status_w[`ST_ZV_BLOCK]         = zv_block;
	end

	// APB decode; no wait states, so the access phase always completes
	assign PREADY   = 1'b1;
	assign wr_acc   = PSEL && PENABLE && PWRITE;
	assign setup_rd = PSEL && !PENABLE && !PWRITE;
	assign rd_hit   = (PADDR == `REG_CTRL) || (PADDR == `REG_STATUS) ||
		(PADDR == `REG_CONFIG) || (PADDR == `REG_EVENT);
	assign PSLVERR  = PSEL && PENABLE && !rd_hit;

	// Read mux; unmapped addresses read zero
	always_comb begin
		unique case (PADDR)
			`REG_CTRL:   rd_mux = ctrl_r;
			`REG_STATUS: rd_mux = status_w;
			`REG_CONFIG: rd_mux = config_w;
			`REG_EVENT:  rd_mux = {{(32-NF){1'b0}}, event_r};
			default:     rd_mux = '0;
		endcase
	end

	// Read data captured in the setup cycle, held through the access phase
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			prdata_r <= '0;
		end else if (setup_rd) begin
			prdata_r <= rd_mux;
		end
	end

	assign PRDATA = prdata_r;

	// Control register, only the force-off bit is implemented
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ctrl_r <= `CTRL_RESET;
		end else if (wr_acc && (PADDR == `REG_CTRL)) begin
			ctrl_r <= {31'h0000_0000, PWDATA[`CTRL_FORCE_OFF]};
		end
	end

	// Sticky trip events, write one to clear; a new trip beats the clear
	always_comb begin
		event_nxt = event_r;
		if (wr_acc && (PADDR == `REG_EVENT)) begin
			event_nxt = event_r & ~PWDATA[NF-1:0];
		end
		event_nxt = event_nxt | (tripped & ~tripped_d_r);
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			event_r     <= '0;
			tripped_d_r <= '0;
		end else begin
			event_r     <= event_nxt;
			tripped_d_r <= tripped;
		end
	end

	a_event_set_wins: assert property ((tripped & ~tripped_d_r) != '0 |=>
		(event_r & $past(tripped & ~tripped_d_r)) == $past(tripped & ~tripped_d_r))
		else $error("trip event lost");

endmodule

`default_nettype wire

// *** fet_pair_model.sv ***
// Behavioural model of the external charge and discharge power FETs
`timescale 1ns/10ps
`default_nettype none

module fet_pair_model (
	input  wire logic                     chg_gate_in,  // Charge FET gate
	input  wire logic                     dsg_gate_in,  // Discharge FET gate
	output wire cell_prot_pkg::fet_drive_t conduct_out  // FET conducting flags
);
	// Gate level passes through; an unknown gate stays unknown so the bench cannot read it as off
	assign conduct_out = {chg_gate_in, dsg_gate_in};
endmodule

`default_nettype wire

// *** tb_cell_protection_fault_timing.sv ***
// Self-checking testbench for the cell protection fault timing block
`timescale 1ns/10ps
`default_nettype none

module tb_cell_protection_fault_timing;
	logic                      clk = 1'b0;     // System clock
	logic                      arst_n = 1'b0;  // Reset, active low
	cell_prot_pkg::fault_vec_t det = '0;       // Fault comparators
	cell_prot_pkg::fault_vec_t rel = '0;       // Release comparators
	logic                      chg_start = 1'b1; // Charger above start level
	logic                      below_inh = 1'b0; // Cell below inhibit level
	logic                      psel = 1'b0;    // APB select
	logic                      penable = 1'b0; // APB enable
	logic                      pwrite = 1'b0;  // APB direction
	logic [7:0]                paddr = 8'h00;  // APB address
	logic [31:0]               pwdata = 32'h0000_0000; // APB write data
	wire logic [31:0]          prdata;         // APB read data
	wire logic                 pready;         // APB ready
	wire logic                 pslverr;        // APB error
	wire logic                 chg_gate;       // Charge gate
	wire logic                 dsg_gate;       // Discharge gate
	wire logic                 chg_gate_inh;   // Charge gate, inhibit twin
	localparam int             REC_TICKS = 8;  // Recovery ticks at the bench's delay divisor
	wire cell_prot_pkg::fet_drive_t fet;       // FET conduction seen by the model
	int                        error_cnt = 0;  // Mismatches
	int                        compares = 0;   // Comparisons made

	// 4 ns clock
	always #2 clk = ~clk;

	// Short timebase so every delay is a few hundred cycles at most
	cell_protection_fault_timing #(.TICK_CYCLES(1), .DELAY_DIV(1000)) u_dut (
		.CLK_IN(clk), .ARST_N_IN(arst_n), .DETECT_IN(det), .RELEASE_IN(rel),
		.CHARGER_ABOVE_START_IN(chg_start), .CELL_BELOW_INHIBIT_IN(below_inh),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CHARGE_FET_DRIVE_OUT(chg_gate), .DISCHARGE_FET_DRIVE_OUT(dsg_gate));

	// Twin with zero-volt charging disallowed, so the inhibit path is exercised too
	cell_protection_fault_timing #(.TICK_CYCLES(1), .DELAY_DIV(1000), .ZV_ALLOW(1'b0)) u_dut_inh (
		.CLK_IN(clk), .ARST_N_IN(arst_n), .DETECT_IN(det), .RELEASE_IN(rel),
		.CHARGER_ABOVE_START_IN(chg_start), .CELL_BELOW_INHIBIT_IN(below_inh),
		.PSEL(1'b0), .PENABLE(1'b0), .PWRITE(1'b0), .PADDR(8'h00), .PWDATA(32'h0000_0000),
		.PRDATA(), .PREADY(), .PSLVERR(),
		.CHARGE_FET_DRIVE_OUT(chg_gate_inh), .DISCHARGE_FET_DRIVE_OUT());

	// Far-side FET pair
	fet_pair_model u_fets (.chg_gate_in(chg_gate), .dsg_gate_in(dsg_gate), .conduct_out(fet));

	// Verdict and end of run
	task automatic close_out();
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Value comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Let n rising edges pass
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Wait for one FET to reach a level, bounded
	task automatic wait_fet(input logic is_chg, input logic v, input int max);
		int n;
		n = 0;
		while ((is_chg ? fet.charge_fet : fet.discharge_fet) !== v && n < max) begin
			@(posedge clk);
			n++;
		end
		chk(is_chg ? fet.charge_fet : fet.discharge_fet, v);
		if ((is_chg ? fet.charge_fet : fet.discharge_fet) !== v) close_out();
	endtask

	// One APB transfer, waiting on pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			close_out();
		end
	endtask

	// Trip after the delay, then recover after the recovery delay
	task automatic fault(input int b, input int lim, input logic is_chg);
		cyc(1);
		det[b] <= 1'b1;
		// Expiry, state flip and drive register each take one edge after the last tick
		cyc(lim + 2);
		chk(is_chg ? fet.charge_fet : fet.discharge_fet, 1'b1);
		wait_fet(is_chg, 1'b0, 2);
		cyc(1);
		det[b] <= 1'b0;
		rel[b] <= 1'b1;
		cyc(REC_TICKS + 2);
		chk(is_chg ? fet.charge_fet : fet.discharge_fet, 1'b0);
		wait_fet(is_chg, 1'b1, 2);
		chk(is_chg ? fet.discharge_fet : fet.charge_fet, 1'b1);
		rel[b] <= 1'b0;
	endtask

	// A short overcurrent blip must leave the drive alone
	task automatic glitch();
		cyc(1);
		det.ocd <= 1'b1;
		cyc(1);
		det.ocd <= 1'b0;
		cyc(3);
		chk(fet.discharge_fet, 1'b1);
		det.ocd <= 1'b1;
		cyc(4);
		det.ocd <= 1'b0;
		cyc(20);
		chk(fet.discharge_fet, 1'b1);
	endtask

	// Depleted cell: charge held off until the charger is high enough
	task automatic zero_volt();
		cyc(1);
		chg_start <= 1'b0;
		below_inh <= 1'b1;
		wait_fet(1'b1, 1'b0, 6);
		chg_start <= 1'b1;
		wait_fet(1'b1, 1'b1, 6);
		chk(chg_gate_inh, 1'b0);
		below_inh <= 1'b0;
		cyc(3);
		chk(chg_gate_inh, 1'b1);
	endtask

	// Fixed configuration, unmapped access and forced off
	task automatic regs();
		logic [31:0] q;
		logic        e;
		apb(1'b0, 8'h08, 32'h0000_0000, q, e);
		chk(q, (32'h1 << 19) | (32'h2 << 4) | 32'h7);
		apb(1'b1, 8'h08, 32'h0000_0000, q, e);
		apb(1'b0, 8'h08, 32'h0000_0000, q, e);
		chk(q, (32'h1 << 19) | (32'h2 << 4) | 32'h7);
		chk({31'h0, e}, 32'h0);
		apb(1'b0, 8'h10, 32'h0000_0000, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		apb(1'b1, 8'h00, 32'h0000_0001, q, e);
		apb(1'b0, 8'h00, 32'h0000_0000, q, e);
		chk(q, 32'h0000_0001);
		wait_fet(1'b0, 1'b0, 6);
		chk(fet.charge_fet, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0000, q, e);
		wait_fet(1'b1, 1'b1, 6);
		chk(fet.discharge_fet, 1'b1);
		apb(1'b0, 8'h04, 32'h0000_0000, q, e);
		chk(q, 32'h0000_0003);
		apb(1'b0, 8'h0c, 32'h0000_0000, q, e);
		chk(q, 32'h0000_001f);
		apb(1'b1, 8'h0c, 32'h0000_001f, q, e);
		apb(1'b0, 8'h0c, 32'h0000_0000, q, e);
		chk(q, 32'h0000_0000);
	endtask

	// Main sequence
	initial begin
		cyc(12);
		arst_n <= 1'b1;
		cyc(2);
		chk({30'h0, fet}, 32'h3);
		fault(2, 8, 1'b0);
		fault(1, 1, 1'b0);
		fault(3, 20, 1'b0);
		fault(0, 4, 1'b1);
		fault(4, 250, 1'b1);
		glitch();
		zero_volt();
		regs();
		close_out();
	end
endmodule

`default_nettype wire
